// ==== verilog/smb_pkg.sv ====
// Purpose: shared constants and types for the management-bus slave port and its master
// Assumes: one 50 MHz system clock on both ends
// Notes:   slave addresses, pulse indices, pointer reset value and bus timing live here
package smb_pkg;

  // ------------------------------------------------------------
  // slave addresses chosen by the straps
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_FIXED  = 7'h2e; // strap enable high
  localparam logic [6:0] ADDR_SEL_LO = 7'h2c; // select mode, select strap low
  localparam logic [6:0] ADDR_SEL_HI = 7'h2d; // select mode, select strap high

  // ------------------------------------------------------------
  // byte framing
  // ------------------------------------------------------------
  localparam logic       RW_WRITE      = 1'b0;  // direction bit, write
  localparam logic       RW_READ       = 1'b1;  // direction bit, read
  localparam logic [3:0] ACK_SLOT      = 4'h8;  // ninth pulse index
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;  // eighth pulse index
  localparam logic [7:0] PTR_RESET     = 8'h00; // pointer after reset

  // ------------------------------------------------------------
  // bus timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;   // clk_sys period
  localparam int SCL_QUARTER_NS  = 2500; // quarter of a 100 kHz clock period
  // least time, rounded up to whole cycles
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // master command kinds
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SMB_SEND,  // pointer write only
    SMB_WRITE, // pointer then data
    SMB_RECV,  // one byte from current pointer
    SMB_READ   // pointer, repeated start, one byte
  } smb_kind_e;

endpackage

// ==== verilog/smb_if.sv ====
// Purpose: two-wire bus joining the master end and the slave end
// Assumes: open-drain wires with pull-ups, modelled by the enables
// Notes:   an enable high means that end drives its output value
`timescale 1ns/1ps
`default_nettype none
interface smb_if;

  // ------------------------------------------------------------
  // per-end drivers and resolved wire levels
  // ------------------------------------------------------------
  logic host_scl_o;  // master clock value
  logic host_scl_oe; // master drives clock
  logic host_sda_o;  // master data value
  logic host_sda_oe; // master drives data
  logic dev_sda_o;   // slave data value
  logic dev_sda_oe;  // slave drives data
  logic scl;         // resolved clock
  logic sda;         // resolved data

  // wired-and with pull-up when nobody drives
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host (
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe,
    input  scl,
    input  sda
  );

  modport dev (
    output dev_sda_o,
    output dev_sda_oe,
    input  scl,
    input  sda
  );

endinterface
`default_nettype wire

// ==== verilog/smb_dev.sv ====
// Purpose: slave end of the management bus, giving access to internal byte registers
// Assumes: bus lines are synchronous to clk_sys; clock is never stretched
// Notes:   register file sits outside; reg_rdata must follow reg_addr
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] strap enable high gives fixed address
// [R2] strap enable low: select strap picks address
// [R3] track straps, latch on first match
// [R4] seven address bits plus direction bit
// [R5] nine pulses per byte, slave acknowledges
// [R6] data rising while clock high is stop
// [R7] master stops after last written byte
// [R8] master nacks read, then stops
// [R9] direction fixed by address byte
// [R10] writes one or two bytes, read one
// [R11] first written byte loads pointer
// [R12] second written byte stores to register
// [R13] plain read uses retained pointer
// [R14] send byte sets pointer
// [R15] write byte stores data
// [R16] receive byte returns one byte
// [R17] repeated start replaces stop
// [R18] read byte: pointer, restart, read
// [R19] mismatched address not acknowledged, ignored
// [R20] start resets bit and byte counters
module smb_dev
  import smb_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       ce,
  smb_if.dev              bus,
  input  wire logic       address_strap_enable,
  input  wire logic       address_strap_select,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            addr_locked,
  output logic      [6:0] slave_addr
);

  // ------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, // no frame open
    ST_ADDR, // receiving address byte
    ST_CMD,  // receiving pointer byte
    ST_DATA, // receiving data byte
    ST_TX,   // sending the read byte
    ST_SKIP  // ignoring until start or stop
  } smb_dst_e;

  smb_dst_e   state;          // frame position
  smb_dst_e   next_state;
  logic [3:0] bitcnt;         // pulse index in byte
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;          // shift in and out
  logic [7:0] next_shreg;
  logic       ack_phase;      // inside ninth pulse
  logic       next_ack_phase;
  logic       sda_oe;         // pull data low
  logic       next_sda_oe;
  logic       sda_o;          // drive value, always low
  logic       rw;             // direction of this frame
  logic       next_rw;
  logic       hit;            // address matched
  logic       next_hit;
  logic [7:0] next_ptr;
  logic [7:0] next_wdata;
  logic       next_wr;
  logic       next_rd;
  logic       next_locked;
  logic [6:0] next_addr;

  // ------------------------------------------------------------
  // line sampling and edge detection
  // ------------------------------------------------------------
  logic s_scl; // current clock sample
  logic p_scl; // previous clock sample
  logic s_sda; // current data sample
  logic p_sda; // previous data sample
  logic rise;  // clock went high
  logic fall;  // clock went low
  logic start_ev;
  logic stop_ev;
  logic [6:0] strap_addr;

  // two stored samples give edges without looking at raw inputs twice
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_scl <= 1'b1;
      p_scl <= 1'b1;
      s_sda <= 1'b1;
      p_sda <= 1'b1;
    end else if (ce) begin
      s_scl <= bus.scl;
      p_scl <= s_scl;
      s_sda <= bus.sda;
      p_sda <= s_sda;
    end
  end

  assign rise     = s_scl & ~p_scl;
  assign fall     = ~s_scl & p_scl;
  // data edges only count while the clock stays high
  assign start_ev = s_scl & p_scl & p_sda & ~s_sda;
  assign stop_ev  = s_scl & p_scl & ~p_sda & s_sda; // [R6]

  // strap decode, straps are level inputs
  always_comb begin
    if (address_strap_enable) begin
      strap_addr = ADDR_FIXED; // [R1]
    end else if (address_strap_select) begin
      strap_addr = ADDR_SEL_HI; // [R2]
    end else begin
      strap_addr = ADDR_SEL_LO; // [R2]
    end
  end

  // ------------------------------------------------------------
  // frame sequencer, next values
  // ------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_bitcnt    = bitcnt;
    next_shreg     = shreg;
    next_ack_phase = ack_phase;
    next_sda_oe    = sda_oe;
    next_rw        = rw;
    next_hit       = hit;
    next_ptr       = reg_addr;
    next_wdata     = reg_wdata;
    next_wr        = 1'b0;
    next_rd        = 1'b0;
    next_locked    = addr_locked;
    next_addr      = slave_addr;
    // follow the straps until the first matching address
    if (!addr_locked) begin
      next_addr = strap_addr; // [R3]
    end
    if (start_ev) begin
      // start and repeated start both reopen at the address byte
      next_state     = ST_ADDR; // [R17]
      next_bitcnt    = 4'h0;    // [R20]
      next_ack_phase = 1'b0;    // [R20]
      next_sda_oe    = 1'b0;
      next_hit       = 1'b0;
    end else if (stop_ev) begin
      next_state     = ST_IDLE; // [R6]
      next_ack_phase = 1'b0;
      next_sda_oe    = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE, ST_SKIP: begin
          // line stays released, nothing to do
          next_sda_oe = 1'b0; // [R19]
        end
        ST_ADDR, ST_CMD, ST_DATA: begin
          if (rise && bitcnt < ACK_SLOT) begin
            // msb first, eight data pulses
            next_shreg  = {shreg[6:0], s_sda}; // [R5]
            next_bitcnt = bitcnt + 4'h1;
            if (state == ST_ADDR && bitcnt == LAST_DATA_BIT) begin
              // seven bits are in, the eighth is direction
              next_rw  = s_sda;                       // [R4] [R9]
              next_hit = (shreg[6:0] == slave_addr);  // [R4]
              if (shreg[6:0] == slave_addr) begin
                next_locked = 1'b1; // [R3]
              end
            end
          end else if (fall && bitcnt == ACK_SLOT && !ack_phase) begin
            next_ack_phase = 1'b1;
            if (state == ST_ADDR && !hit) begin
              // foreign address, keep the line free
              next_state = ST_SKIP; // [R19]
            end else begin
              next_sda_oe = 1'b1; // [R5]
              if (state == ST_CMD) begin
                next_ptr = shreg; // [R11] [R14]
              end
              if (state == ST_DATA) begin
                next_wdata = shreg; // [R12] [R15]
                next_wr    = 1'b1;  // [R12]
              end
              if (state == ST_ADDR && rw == RW_READ) begin
                next_rd = 1'b1; // [R13]
              end
            end
          end else if (fall && ack_phase) begin
            // end of ninth pulse, release and move on
            next_ack_phase = 1'b0;
            next_bitcnt    = 4'h0;
            next_sda_oe    = 1'b0;
            unique case (state)
              ST_ADDR: begin
                if (rw == RW_READ) begin
                  // read from the retained pointer
                  next_state  = ST_TX;         // [R13] [R16] [R18]
                  next_shreg  = reg_rdata;     // [R13]
                  next_sda_oe = ~reg_rdata[7]; // [R16]
                end else begin
                  next_state = ST_CMD; // [R9]
                end
              end
              ST_CMD: begin
                next_state = ST_DATA; // [R15]
              end
              default: begin
                // a third written byte gets no acknowledge
                next_state = ST_SKIP; // [R10]
              end
            endcase
          end
        end
        ST_TX: begin
          if (rise) begin
            if (bitcnt < ACK_SLOT) begin
              next_bitcnt = bitcnt + 4'h1;
            end else begin
              // master answer is not needed: one byte only
              next_state = ST_SKIP; // [R10] [R8]
            end
          end else if (fall) begin
            if (bitcnt < ACK_SLOT) begin
              next_shreg  = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6]; // [R16]
            end else begin
              // free the line for the master answer
              next_sda_oe = 1'b0; // [R8]
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // frame sequencer, registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state       <= ST_IDLE;
      bitcnt      <= 4'h0;
      shreg       <= 8'h00;
      ack_phase   <= 1'b0;
      sda_oe      <= 1'b0;
      sda_o       <= 1'b0;
      rw          <= RW_WRITE;
      hit         <= 1'b0;
      reg_addr    <= PTR_RESET;
      reg_wdata   <= 8'h00;
      reg_wr      <= 1'b0;
      reg_rd      <= 1'b0;
      addr_locked <= 1'b0;
      slave_addr  <= ADDR_FIXED;
    end else if (ce) begin
      state       <= next_state;
      bitcnt      <= next_bitcnt;
      shreg       <= next_shreg;
      ack_phase   <= next_ack_phase;
      sda_oe      <= next_sda_oe;
      sda_o       <= 1'b0;
      rw          <= next_rw;
      hit         <= next_hit;
      reg_addr    <= next_ptr;
      reg_wdata   <= next_wdata;
      reg_wr      <= next_wr;
      reg_rd      <= next_rd;
      addr_locked <= next_locked;
      slave_addr  <= next_addr;
    end
  end

  // open drain: only ever pulls low
  assign bus.dev_sda_o  = sda_o;
  assign bus.dev_sda_oe = sda_oe;

endmodule
`default_nettype wire

// ==== verilog/smb_host.sv ====
// Purpose: master end that runs send, write, receive and read byte transfers
// Assumes: quarter-period ticks from clk_sys; slave never stretches the clock
// Notes:   one command at a time, taken while cmd_ready is high
`timescale 1ns/1ps
`default_nettype none
module smb_host
  import smb_pkg::*;
#(
  parameter int QUARTER_CYC = SCL_QUARTER_CYC
)(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       ce,
  smb_if.host             bus,
  input  wire logic       cmd_valid,
  input  wire smb_kind_e  cmd_kind,
  input  wire logic [6:0] cmd_addr,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_ready,
  output logic            done,
  output logic            nack,
  output logic      [7:0] rdata
);

  // ------------------------------------------------------------
  // items of a transfer and the sequence per kind
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    IT_START, IT_ADDR_W, IT_ADDR_R, IT_CMD, IT_DATA, IT_RX, IT_STOP
  } smb_item_e;

  localparam logic [11:0] QLAST = 12'(QUARTER_CYC - 1); // tick divider end

  function automatic smb_item_e item_at(input smb_kind_e k, input logic [2:0] s);
    smb_item_e it;
    it = IT_STOP;
    unique case (k)
      SMB_SEND:  it = (s == 3'h0) ? IT_START : (s == 3'h1) ? IT_ADDR_W :
                      (s == 3'h2) ? IT_CMD : IT_STOP;
      SMB_WRITE: it = (s == 3'h0) ? IT_START : (s == 3'h1) ? IT_ADDR_W :
                      (s == 3'h2) ? IT_CMD : (s == 3'h3) ? IT_DATA : IT_STOP;
      SMB_RECV:  it = (s == 3'h0) ? IT_START : (s == 3'h1) ? IT_ADDR_R :
                      (s == 3'h2) ? IT_RX : IT_STOP;
      SMB_READ:  it = (s == 3'h0 || s == 3'h3) ? IT_START : (s == 3'h1) ? IT_ADDR_W :
                      (s == 3'h2) ? IT_CMD : (s == 3'h4) ? IT_ADDR_R :
                      (s == 3'h5) ? IT_RX : IT_STOP;
    endcase
    return it;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic        busy;       // transfer running
  logic        next_busy;
  logic [11:0] qcnt;       // quarter divider
  logic [11:0] next_qcnt;
  logic [1:0]  phase;      // quarter within a slot
  logic [1:0]  next_phase;
  logic [2:0]  seg;        // item index
  logic [2:0]  next_seg;
  logic [3:0]  bitcnt;     // pulse in byte
  logic [3:0]  next_bitcnt;
  logic        go_stop;    // abort to stop on nack
  logic        next_go_stop;
  smb_kind_e   kind;       // latched command
  smb_kind_e   next_kind;
  logic [6:0]  addr;
  logic [6:0]  next_addr;
  logic [7:0]  code;
  logic [7:0]  next_code;
  logic [7:0]  data;
  logic [7:0]  next_data;
  logic        scl_oe;
  logic        next_scl_oe;
  logic        sda_oe;
  logic        next_sda_oe;
  logic        next_ready;
  logic        next_done;
  logic        next_nack;
  logic [7:0]  next_rdata;
  smb_item_e   it;         // current item
  logic [7:0]  txb;        // byte to send
  logic        tbit;       // bit of this slot

  assign it = go_stop ? IT_STOP : item_at(kind, seg);

  // byte per item, receive slots keep the line released
  always_comb begin
    unique case (it)
      IT_ADDR_W: txb = {addr, RW_WRITE}; // [R4] [R9]
      IT_ADDR_R: txb = {addr, RW_READ};  // [R4] [R16]
      IT_CMD:    txb = code;             // [R14]
      IT_DATA:   txb = data;             // [R15]
      default:   txb = 8'hff;
    endcase
    // ninth pulse is released: ack from slave or nack from us
    tbit = (bitcnt < ACK_SLOT) ? txb[~bitcnt[2:0]] : 1'b1; // [R5] [R8]
  end

  // ------------------------------------------------------------
  // slot sequencer, next values
  // ------------------------------------------------------------
  always_comb begin
    next_busy = busy;
    next_qcnt = qcnt;
    next_phase = phase;
    next_seg = seg;
    next_bitcnt = bitcnt;
    next_go_stop = go_stop;
    next_kind = kind;
    next_addr = addr;
    next_code = code;
    next_data = data;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_ready = cmd_ready;
    next_done = 1'b0;
    next_nack = nack;
    next_rdata = rdata;
    if (!busy) begin
      next_scl_oe = 1'b0;
      next_sda_oe = 1'b0;
      if (cmd_valid) begin
        next_busy = 1'b1;
        next_ready = 1'b0;
        next_nack = 1'b0;
        next_go_stop = 1'b0;
        next_seg = 3'h0;
        next_bitcnt = 4'h0;
        next_phase = 2'h3;
        next_qcnt = 12'h000;
        next_kind = cmd_kind;
        next_addr = cmd_addr;
        next_code = cmd_code;
        next_data = cmd_data;
      end
    end else if (qcnt != QLAST) begin
      next_qcnt = qcnt + 12'h001;
    end else begin
      next_qcnt  = 12'h000;
      next_phase = phase + 2'h1;
      unique case (next_phase)
        2'h0: begin
          // clock low, set up data for this slot
          next_scl_oe = 1'b1;
          next_sda_oe = (it == IT_STOP) ? 1'b1 : (it == IT_START) ? 1'b0 : ~tbit; // [R6]
        end
        2'h1: begin
          next_scl_oe = 1'b0;
        end
        2'h2: begin
          if (it == IT_START) begin
            next_sda_oe = 1'b1; // [R17]
          end else if (it == IT_STOP) begin
            next_sda_oe = 1'b0; // [R7] [R8]
          end else if (bitcnt < ACK_SLOT) begin
            if (it == IT_RX) begin
              next_rdata = {rdata[6:0], bus.sda}; // [R16]
            end
          end else if (it != IT_RX && bus.sda) begin
            // slave refused, finish with a stop
            next_nack    = 1'b1;
            next_go_stop = 1'b1;
          end
        end
        2'h3: begin
          // a refused byte still ends its ack pulse, then a real stop slot follows
          if (it == IT_STOP && bitcnt != ACK_SLOT) begin
            next_busy  = 1'b0;
            next_ready = 1'b1;
            next_done  = 1'b1;
          end else begin
            next_scl_oe = 1'b1;
            if (it == IT_START || bitcnt == ACK_SLOT) begin
              next_bitcnt = 4'h0;
              next_seg    = seg + 3'h1; // [R18]
            end else begin
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // slot sequencer, registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy <= 1'b0;
      qcnt <= 12'h000;
      phase <= 2'h0;
      seg <= 3'h0;
      bitcnt <= 4'h0;
      go_stop <= 1'b0;
      kind <= SMB_SEND;
      addr <= 7'h00;
      code <= 8'h00;
      data <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      cmd_ready <= 1'b1;
      done <= 1'b0;
      nack <= 1'b0;
      rdata <= 8'h00;
    end else if (ce) begin
      busy <= next_busy;
      qcnt <= next_qcnt;
      phase <= next_phase;
      seg <= next_seg;
      bitcnt <= next_bitcnt;
      go_stop <= next_go_stop;
      kind <= next_kind;
      addr <= next_addr;
      code <= next_code;
      data <= next_data;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      cmd_ready <= next_ready;
      done <= next_done;
      nack <= next_nack;
      rdata <= next_rdata;
    end
  end

  // open drain: enables pull low
  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = sda_oe;

endmodule
`default_nettype wire

// ==== bench/smb_chk.sv ====
// Purpose: wire checks on the bus between master end and slave end
// Assumes: one clock domain, synchronous active-high reset
// Notes:   helper counter tracks clock pulses since the last start
`timescale 1ns/1ps
`default_nettype none
module smb_chk #(
  parameter int QUARTER_CYC = 8
)(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  localparam int START_MAX = 2 * QUARTER_CYC; // start to clock low
  logic [4:0] cnt;      // clock rises since start
  logic       rd;       // direction bit of address byte
  logic       scl_q;    // clock one cycle ago
  logic       sda_q;    // data one cycle ago
  logic [4:0] next_cnt;
  logic       next_rd;
  // ------------------------------------------------------------
  // pulse counter, cleared by any start
  // ------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    next_rd  = rd;
    if (scl && sda_q && !sda) begin
      next_cnt = 5'h00;
      next_rd  = 1'b0;
    end else if (scl && !scl_q) begin
      if (cnt == 5'h07) next_rd = sda;
      if (cnt != 5'h1f) next_cnt = cnt + 5'h01; // saturate, no wrap
    end
  end
  always_ff @(posedge clk_sys) begin
    scl_q <= scl;
    sda_q <= sda;
    cnt   <= srst ? 5'h00 : next_cnt;
    rd    <= srst ? 1'b0 : next_rd;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_start; scl && $fell(sda); endsequence
  sequence s_stop;  scl && $rose(sda); endsequence
  property p_dev_edge; $changed(dev_sda_oe) |-> !scl; endproperty
  // ack handover overlaps only while the clock is low
  property p_no_clash; host_sda_oe && dev_sda_oe |-> !scl; endproperty
  property p_stop_free; s_stop |-> !dev_sda_oe; endproperty
  property p_addr_quiet; $rose(dev_sda_oe) |-> cnt >= 5'h08; endproperty
  property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
  property p_ack_hold; $rose(scl) && cnt == 5'h08 && dev_sda_oe |-> dev_sda_oe [*8]; endproperty
  property p_read_ack; $rose(scl) && rd && cnt == 5'h08 |-> dev_sda_oe; endproperty
  property p_read_free;
    $rose(scl) && rd && cnt >= 5'h09 && cnt <= 5'h11 |-> !host_sda_oe;
  endproperty
  property p_start_clk; s_start |-> ##[1:START_MAX] !scl; endproperty
  a_dev_edge:   assert property (p_dev_edge)   else $error("slave data moved with clock high");
  a_no_clash:   assert property (p_no_clash)   else $error("both ends drive data, clock high");
  a_stop_free:  assert property (p_stop_free)  else $error("slave holds data at stop");
  a_addr_quiet: assert property (p_addr_quiet) else $error("slave drove inside address");
  a_scl_high:   assert property (p_scl_high)   else $error("clock high too short");
  a_ack_hold:   assert property (p_ack_hold)   else $error("ack dropped in pulse");
  a_read_ack:   assert property (p_read_ack)   else $error("read address not acked");
  a_read_free:  assert property (p_read_free)  else $error("master drove read byte");
  a_start_clk:  assert property (p_start_clk)  else $error("no clock after start");
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: drives both ends through every transfer kind
// Assumes: small quarter period so runs stay short
// Notes:   byte registers modelled here, read back directly
`timescale 1ns/1ps
`default_nettype none
module tb;
  import smb_pkg::*;
  localparam int QC = 8; // quarter period, cycles
  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic       cmd_valid = 1'b0;
  smb_kind_e  cmd_kind = SMB_SEND;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic       en_strap = 1'b0;
  logic       sel_strap = 1'b0;
  logic [7:0] regs [256]; // register file model
  logic [7:0] rd_seen = 8'h00; // read notifications so far
  wire  [7:0] reg_addr, reg_wdata, rdata;
  wire        reg_wr, reg_rd, locked, cmd_ready, done, nack;
  wire  [6:0] slave_addr;
  int         err_count = 0;
  int         comparisons = 0;
  always #10 clk_sys = ~clk_sys;
  smb_if bus_if ();
  smb_dev smb_dev_inst (.clk_sys(clk_sys), .srst(srst), .ce(1'b1), .bus(bus_if),
    .address_strap_enable(en_strap), .address_strap_select(sel_strap),
    .reg_rdata(regs[reg_addr]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .addr_locked(locked), .slave_addr(slave_addr));
  smb_host #(.QUARTER_CYC(QC)) smb_host_inst (.clk_sys(clk_sys), .srst(srst), .ce(1'b1),
    .bus(bus_if), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done),
    .nack(nack), .rdata(rdata));
  smb_chk #(.QUARTER_CYC(QC)) smb_chk_inst (.clk_sys(clk_sys), .srst(srst),
    .scl(bus_if.scl), .sda(bus_if.sda), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe));
  // register writes land on the pulse
  always @(posedge clk_sys) begin
    if (reg_wr) regs[reg_addr] <= reg_wdata;
    if (reg_rd === 1'b1) rd_seen <= rd_seen + 8'h01;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset with new strap levels; straps only matter before lock
  task automatic rst(input logic en, input logic sel);
    en_strap = en;
    sel_strap = sel;
    srst = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 srst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // one command, waits for done under a bound
  task automatic run(input smb_kind_e k, input logic [6:0] a, input logic [7:0] c,
                     input logic [7:0] d);
    int n;
    n = 0;
    cmd_kind = k;
    cmd_addr = a;
    cmd_code = c;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n >= 3000) chk(8'h00, 8'h01); // hung transfer counts as a miss
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'h00;
    regs[8'h20] = 8'h3c;
    rst(1'b0, 1'b0);
    chk({1'b0, slave_addr}, {1'b0, ADDR_SEL_LO});
    run(SMB_WRITE, ADDR_SEL_LO, 8'h10, 8'ha5);
    chk(regs[8'h10], 8'ha5);
    chk(reg_addr, 8'h10);
    chk({7'h00, nack}, 8'h00);
    sel_strap = 1'b1; // late strap change must not move the address
    repeat (4) @(posedge clk_sys);
    chk({1'b0, slave_addr}, {1'b0, ADDR_SEL_LO});
    chk({7'h00, locked}, 8'h01);
    run(SMB_RECV, ADDR_SEL_LO, 8'h00, 8'h00);
    chk(rdata, 8'ha5);
    chk(rd_seen, 8'h01);
    run(SMB_SEND, ADDR_SEL_LO, 8'h20, 8'h00);
    chk(reg_addr, 8'h20);
    chk({7'h00, cmd_ready}, 8'h01);
    chk(regs[8'h10], 8'ha5);
    run(SMB_RECV, ADDR_SEL_LO, 8'h00, 8'h00);
    chk(rdata, 8'h3c);
    run(SMB_READ, ADDR_SEL_LO, 8'h10, 8'h00);
    chk(rdata, 8'ha5);
    run(SMB_WRITE, ADDR_SEL_HI, 8'h30, 8'h77);
    chk({7'h00, nack}, 8'h01);
    chk(regs[8'h30], 8'h00);
    chk(reg_addr, 8'h10);
    rst(1'b1, 1'b0);
    chk({1'b0, slave_addr}, {1'b0, ADDR_FIXED});
    run(SMB_READ, ADDR_FIXED, 8'h20, 8'h00);
    chk(rdata, 8'h3c);
    chk(rd_seen, 8'h04);
    rst(1'b0, 1'b1);
    chk({1'b0, slave_addr}, {1'b0, ADDR_SEL_HI});
    run(SMB_WRITE, ADDR_SEL_HI, 8'h40, 8'h5a);
    chk(regs[8'h40], 8'h5a);
    final_report();
  end
  // watchdog well past the longest expected run
  initial begin
    #600000;
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
